// ### hdl/iacs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "iacs_map.vh"
// Operation
// - Call mode sends three bytes, opcode first
// - Order: opcode, address low, address high
// - Vector mode sends one vector byte
// - Low address bits filled from level
// - Gap 4: A7..A5, level, 00
// - Gap 8: A7..A6, level, 000
// - Vector byte: V7..V3 then level
// - Latch request; raise output if highest
// - Acknowledge sets in-service, clears request in edge mode
// - A0 low, D4 high is first word
// - Default init resets edges, clears edge requests
// - Default init clears in-service and mask
// - Default init restores fixed priority
// - Default init leaves exceptional nesting, reads requests
// - Default init clears fourth word
// - Write after first word is second word
// - Third word if cascaded, fourth if requested
// - Single-chip bit selects single or cascaded
// - Fourth-word request bit demands fourth word
// - After init, commands accepted in any order
module iacs_top (
  input  wire       CLK_SYS,
  input  wire       RST_N,
  input  wire [7:0] IRQ_REQUEST_IN,
  input  wire       CS_N,
  input  wire       RD_N,
  input  wire       WR_N,
  input  wire       ADDR0,
  input  wire [7:0] DATA_IN,
  input  wire       IRQ_ACKNOWLEDGE_N,
  output reg  [7:0] DATA_OUT,
  output reg        DATA_OE,
  output reg        INT_OUT,
  output reg        INIT_BUSY,
  output reg        VECTOR_MODE
);
  reg  [7:0] request_latch_reg;
  reg  [7:0] in_service_reg;
  reg  [7:0] mask_reg;
  reg  [7:0] init_word_first;
  reg  [7:0] init_word_second;
  reg  [7:0] init_word_third;
  reg  [7:0] init_word_fourth;
  reg  [1:0] init_state;
  reg        read_isr;
  reg        exc_nest;
  reg        wr_prev;
  reg        ack_prev;
  reg  [1:0] ack_count;
  reg  [2:0] ack_level;
  wire       wr_go;
  wire       ack_fall;
  wire       ack_rise;
  wire       level_mode;
  wire       is_iw1;
  wire       default_init;
  wire [7:0] rise;
  wire [7:0] cand;
  wire [7:0] isr_view;
  wire [7:0] svc_block;
  wire       cand_found;
  wire [2:0] cand_level;
  wire       isr_found;
  wire [2:0] isr_level;
  wire       vec_sel;
  wire [7:0] low_byte;
  wire [7:0] vec_byte;
  reg  [7:0] ack_byte;
  reg  [1:0] next_init_state;

  assign wr_go        = ~CS_N & ~WR_N & RD_N & wr_prev;
  assign ack_fall     = ~IRQ_ACKNOWLEDGE_N & ack_prev;
  assign ack_rise     = IRQ_ACKNOWLEDGE_N & ~ack_prev;
  assign level_mode   = init_word_first[`IACS_IW1_LEVEL];
  assign is_iw1       = wr_go & ~ADDR0 & DATA_IN[`IACS_IW1_MARK_BIT];
  assign default_init = is_iw1;
  assign vec_sel      = init_word_fourth[`IACS_IW4_VECTOR];

  iacs_edge u_edge (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .clr    (default_init),
    .req_in (IRQ_REQUEST_IN),
    .rise   (rise)
  );

  // Exceptional nesting lets the mask hide in-service levels
  assign isr_view = exc_nest ? (in_service_reg & ~mask_reg) : in_service_reg;

  iacs_prio u_isr_prio (
    .found (isr_found),
    .level (isr_level),
    .cand  (isr_view)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_blk
      localparam integer lvl = g;
      assign svc_block[g] = isr_found & ({29'h0, isr_level} <= lvl);
    end
  endgenerate

  assign cand = request_latch_reg & ~mask_reg & ~svc_block;

  iacs_prio u_req_prio (
    .cand  (cand),
    .found (cand_found),
    .level (cand_level)
  );

  // Low address byte per gap select
  assign low_byte = init_word_first[`IACS_IW1_GAP4] ?
                    {init_word_first[7:5], ack_level, 2'b00} :
                    {init_word_first[7:6], ack_level, 3'b000};
  assign vec_byte = {init_word_second[7:3], ack_level};

  always @* begin
    ack_byte = `IACS_RESET_BYTE;
    if (vec_sel) begin
      ack_byte = vec_byte;
    end else begin
      case (ack_count)
        2'h0:    ack_byte = `IACS_OP_CALL;
        2'h1:    ack_byte = low_byte;
        2'h2:    ack_byte = init_word_second;
        default: ack_byte = `IACS_RESET_BYTE;
      endcase
    end
  end

  // Init sequencing
  always @* begin
    next_init_state = init_state;
    if (is_iw1) begin
      next_init_state = `IACS_INIT_WAIT2;
    end else if (wr_go & ADDR0) begin
      case (init_state)
        `IACS_INIT_WAIT2: begin
          if (!init_word_first[`IACS_IW1_SINGLE])
            next_init_state = `IACS_INIT_WAIT3;
          else if (init_word_first[`IACS_IW1_FOURTH])
            next_init_state = `IACS_INIT_WAIT4;
          else
            next_init_state = `IACS_INIT_IDLE;
        end
        `IACS_INIT_WAIT3: begin
          if (init_word_first[`IACS_IW1_FOURTH])
            next_init_state = `IACS_INIT_WAIT4;
          else
            next_init_state = `IACS_INIT_IDLE;
        end
        `IACS_INIT_WAIT4: next_init_state = `IACS_INIT_IDLE;
        default:          next_init_state = `IACS_INIT_IDLE;
      endcase
    end
  end

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wr_prev          <= 1'b1;
      ack_prev         <= 1'b1;
      init_state       <= `IACS_INIT_IDLE;
      init_word_first  <= `IACS_RESET_BYTE;
      init_word_second <= `IACS_RESET_BYTE;
      init_word_third  <= `IACS_RESET_BYTE;
      init_word_fourth <= `IACS_RESET_BYTE;
      request_latch_reg <= `IACS_RESET_BYTE;
      in_service_reg   <= `IACS_RESET_BYTE;
      mask_reg         <= `IACS_RESET_BYTE;
      read_isr         <= 1'b0;
      exc_nest         <= 1'b0;
      ack_count        <= 2'h0;
      ack_level        <= 3'h0;
      DATA_OUT         <= `IACS_RESET_BYTE;
      DATA_OE          <= 1'b0;
      INT_OUT          <= 1'b0;
      INIT_BUSY        <= 1'b0;
      VECTOR_MODE      <= 1'b0;
    end else begin
      wr_prev    <= ~(~CS_N & ~WR_N);
      ack_prev   <= IRQ_ACKNOWLEDGE_N;
      init_state <= next_init_state;
      INIT_BUSY  <= (next_init_state != `IACS_INIT_IDLE);
      VECTOR_MODE <= vec_sel;
      // Request latch: edge or level, set beats acknowledge clear
      if (default_init) begin
        if (!DATA_IN[`IACS_IW1_LEVEL])
          request_latch_reg <= `IACS_RESET_BYTE;
        else
          request_latch_reg <= IRQ_REQUEST_IN;
      end else if (level_mode) begin
        request_latch_reg <= IRQ_REQUEST_IN;
      end else begin
        request_latch_reg <= (request_latch_reg & ~((ack_fall && ack_count == 2'h0) ?
                             (8'h01 << cand_level) : 8'h00)) | rise;
      end
      if (is_iw1) begin
        init_word_first  <= DATA_IN;
        init_word_fourth <= `IACS_RESET_BYTE;
        in_service_reg   <= `IACS_RESET_BYTE;
        mask_reg         <= `IACS_RESET_BYTE;
        exc_nest         <= 1'b0;
        read_isr         <= 1'b0;
        ack_count        <= 2'h0;
        INT_OUT          <= 1'b0;
        DATA_OE          <= 1'b0;
      end else begin
        if (wr_go & ADDR0) begin
          case (init_state)
            `IACS_INIT_WAIT2: init_word_second <= DATA_IN;
            `IACS_INIT_WAIT3: init_word_third  <= DATA_IN;
            `IACS_INIT_WAIT4: init_word_fourth <= DATA_IN;
            default:          mask_reg         <= DATA_IN;
          endcase
        end else if (wr_go & ~ADDR0 & (init_state == `IACS_INIT_IDLE)) begin
          if (DATA_IN[`IACS_MCW_BIT]) begin
            if (DATA_IN[`IACS_MCW_READ_EN])
              read_isr <= DATA_IN[`IACS_MCW_READ_ISR];
            if (DATA_IN[`IACS_MCW_EXC_EN])
              exc_nest <= DATA_IN[`IACS_MCW_EXC_NEST];
          end else if (DATA_IN[`IACS_PF_FI_BIT]) begin
            if (DATA_IN[`IACS_PF_SPEC_BIT])
              in_service_reg[DATA_IN[2:0]] <= 1'b0;
            else if (isr_found)
              in_service_reg[isr_level] <= 1'b0;
          end
        end
        // Acknowledge sequence
        if (ack_fall) begin
          if (ack_count == 2'h0) begin
            ack_level <= cand_level;
            in_service_reg[cand_level] <= 1'b1;
            INT_OUT <= 1'b0;
            if (!vec_sel) begin
              DATA_OUT <= `IACS_OP_CALL;
              DATA_OE  <= 1'b1;
            end
          end else begin
            DATA_OUT <= ack_byte;
            DATA_OE  <= 1'b1;
          end
        end else if (ack_rise) begin
          DATA_OE <= 1'b0;
          // Call mode: 3 pulses; vector mode: 2
          if ((vec_sel && ack_count == 2'h1) || (!vec_sel && ack_count == 2'h2)) begin
            ack_count <= 2'h0;
            if (init_word_fourth[`IACS_IW4_SELF_FIN])
              in_service_reg[ack_level] <= 1'b0;
          end else begin
            ack_count <= ack_count + 2'h1;
          end
        end else if (!CS_N & !RD_N & WR_N) begin
          DATA_OE  <= 1'b1;
          DATA_OUT <= ADDR0 ? mask_reg : (read_isr ? in_service_reg : request_latch_reg);
        end else if ((ack_count == 2'h0) & IRQ_ACKNOWLEDGE_N) begin
          // Idle only with acknowledge high, so the first byte stands
          DATA_OE <= 1'b0;
          // Output dropped while a write strobe is low
          INT_OUT <= cand_found & (init_state == `IACS_INIT_IDLE) & ~(~CS_N & ~WR_N);
        end
      end
    end
  end
endmodule // iacs_top
`default_nettype wire

// ### hdl/iacs_map.vh
`ifndef IACS_MAP_VH
`define IACS_MAP_VH
`define IACS_OP_CALL       8'hcd
`define IACS_IW1_MARK_BIT  4
`define IACS_IW1_FOURTH    0
`define IACS_IW1_SINGLE    1
`define IACS_IW1_GAP4      2
`define IACS_IW1_LEVEL     3
`define IACS_IW1_ADDR_LSB  5
`define IACS_IW4_VECTOR    0
`define IACS_IW4_SELF_FIN  1
`define IACS_IW4_EXT_NEST  4
`define IACS_MCW_BIT       3
`define IACS_MCW_READ_ISR  0
`define IACS_MCW_READ_EN   1
`define IACS_MCW_EXC_NEST  5
`define IACS_MCW_EXC_EN    6
`define IACS_PF_FI_BIT     5
`define IACS_PF_SPEC_BIT   6
`define IACS_RESET_BYTE    8'h00
`define IACS_INIT_IDLE     2'h0
`define IACS_INIT_WAIT2    2'h1
`define IACS_INIT_WAIT3    2'h2
`define IACS_INIT_WAIT4    2'h3
`endif

// ### hdl/iacs_prio.v
`timescale 1ns/1ps
`default_nettype none
module iacs_prio (
  input  wire [7:0] cand,
  output reg        found,
  output reg  [2:0] level
);
  integer i;
  // Fixed priority, input 0 highest
  always @* begin
    found = 1'b0;
    level = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        found = 1'b1;
        level = i[2:0];
      end
    end
  end
endmodule // iacs_prio
`default_nettype wire

// ### hdl/iacs_edge.v
`timescale 1ns/1ps
`default_nettype none
module iacs_edge (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clr,
  input  wire [7:0] req_in,
  output wire [7:0] rise
);
  reg [7:0] prev;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_edge
      // Clear forces prev high so a held level needs a fresh edge
      always @(posedge clk) begin
        if (!rst_n)
          prev[g] <= 1'b1;
        else if (clr)
          prev[g] <= 1'b1;
        else
          prev[g] <= req_in[g];
      end
      assign rise[g] = req_in[g] & ~prev[g];
    end
  endgenerate
endmodule // iacs_edge
`default_nettype wire

// ### sim/iacs_props.sv
`timescale 1ns/1ps
`default_nettype none
module iacs_props (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic       CS_N,
  input wire logic       RD_N,
  input wire logic       WR_N,
  input wire logic       ADDR0,
  input wire logic [7:0] DATA_IN,
  input wire logic       IRQ_ACKNOWLEDGE_N,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE,
  input wire logic       INT_OUT,
  input wire logic       INIT_BUSY,
  input wire logic       VECTOR_MODE
);
  logic pend;
  wire  iw1 = !CS_N && !WR_N && RD_N && !ADDR0 && DATA_IN[4];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Set by a raised interrupt until its first driven byte
  always @(posedge CLK_SYS) begin
    if (!RST_N) pend <= 1'b0;
    else if (INT_OUT) pend <= 1'b1;
    else if (DATA_OE) pend <= 1'b0;
  end
  chk_first_opcode: assert property ($rose(DATA_OE) && $past(RD_N) && pend && !VECTOR_MODE
    |-> DATA_OUT == 8'hcd)
    else $error("first call byte is not the opcode");
  chk_oe_cause: assert property (DATA_OE |-> !$past(IRQ_ACKNOWLEDGE_N) || !$past(IRQ_ACKNOWLEDGE_N, 2)
    || !$past(RD_N) || !$past(RD_N, 2))
    else $error("data driven without acknowledge or read");
  chk_oe_release: assert property (DATA_OE && IRQ_ACKNOWLEDGE_N && RD_N |-> ##[1:2] !DATA_OE)
    else $error("data bus held after acknowledge ended");
  chk_ack_clears_int: assert property (INT_OUT && $fell(IRQ_ACKNOWLEDGE_N) |-> ##[1:2] !INT_OUT)
    else $error("interrupt stays up after acknowledge");
  chk_init_starts: assert property (iw1 |-> ##[1:2] INIT_BUSY)
    else $error("first init word did not start init");
  chk_init_call_mode: assert property (iw1 |-> ##[1:2] !VECTOR_MODE)
    else $error("first init word left vector mode set");
  chk_busy_quiet: assert property (INIT_BUSY && $past(INIT_BUSY) |-> !INT_OUT)
    else $error("interrupt raised during init");
  chk_int_after_init: assert property ($rose(INT_OUT) |-> !INIT_BUSY)
    else $error("interrupt rose while init busy");
endmodule // iacs_props
bind iacs_top iacs_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
  .ADDR0(ADDR0), .DATA_IN(DATA_IN), .IRQ_ACKNOWLEDGE_N(IRQ_ACKNOWLEDGE_N), .DATA_OUT(DATA_OUT),
  .DATA_OE(DATA_OE), .INT_OUT(INT_OUT), .INIT_BUSY(INIT_BUSY), .VECTOR_MODE(VECTOR_MODE));
`default_nettype wire

// ### sim/iacs_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module iacs_cpu (
  input  wire logic       clk,
  input  wire logic [7:0] dout,
  input  wire logic       doe,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            a0,
  output logic [7:0]      dat,
  output logic            ack_n
);
  initial begin
    {cs_n, rd_n, wr_n, ack_n} = 4'hf;
    a0 = 1'b0;
    dat = 8'h00;
  end
  // One write, taken on the first low edge; released bus shows inverse
  task automatic wr(input logic adr, input logic [7:0] d);
    @(posedge clk);
    #1;
    {cs_n, wr_n, a0, dat} = {2'b00, adr, d};
    @(posedge clk);
    #1;
    {cs_n, wr_n, dat} = {2'b11, ~d};
  endtask
  // One read; data taken while the strobe still stands
  task automatic rd(input logic adr, output logic [7:0] d);
    @(posedge clk);
    #1;
    {cs_n, rd_n, a0} = {2'b00, adr};
    repeat (2) @(posedge clk);
    #1;
    d = dout;
    {cs_n, rd_n} = 2'b11;
    @(posedge clk);
  endtask
  // One low acknowledge pulse; byte taken while it stands
  task automatic ack(output logic [7:0] d, output logic oe);
    @(posedge clk);
    #1;
    ack_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    d = dout;
    oe = doe;
    ack_n = 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule // iacs_cpu
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] req     = 8'h00;
  logic [7:0] b;
  logic       oe;
  int         mismatches = 0;
  int         checks_done = 0;
  wire        cs_n, rd_n, wr_n, a0, ack_n, doe, intr, busy, vmode;
  wire  [7:0] dat, dout;
  always #4 clk_sys = ~clk_sys;
  iacs_cpu cpu (.clk(clk_sys), .dout(dout), .doe(doe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .a0(a0), .dat(dat), .ack_n(ack_n));
  iacs_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .IRQ_REQUEST_IN(req), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .ADDR0(a0), .DATA_IN(dat), .IRQ_ACKNOWLEDGE_N(ack_n), .DATA_OUT(dout),
    .DATA_OE(doe), .INT_OUT(intr), .INIT_BUSY(busy), .VECTOR_MODE(vmode));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3, input logic [7:0] w4);
    cpu.wr(1'b0, w1);
    chk(busy, 1'b1);
    cpu.wr(1'b1, w2);
    chk(busy, !w1[1] || w1[0]);
    if (!w1[1]) cpu.wr(1'b1, w3);
    if (w1[0]) cpu.wr(1'b1, w4);
    chk(busy, 1'b0);
    // Mode output is a registered copy, one cycle behind the last word
    @(posedge clk_sys);
    #1;
    chk(vmode, w1[0] & w4[0]);
  endtask
  // Raise requests, wait for the interrupt, run the acknowledge pulses
  task automatic svc(input logic [7:0] r, input logic vec, input logic [7:0] lo, input logic [7:0] hi);
    int i;
    @(posedge clk_sys);
    #1;
    req = r;
    for (i = 0; i < 20 && intr !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(intr, 1'b1);
    cpu.ack(b, oe);
    if (vec) begin
      chk(oe, 1'b0);
      cpu.ack(b, oe);
      chk(b, lo);
      chk(oe, 1'b1);
    end else begin
      chk(b, 8'hcd);
      chk(oe, 1'b1);
      cpu.ack(b, oe);
      chk(b, lo);
      cpu.ack(b, oe);
      chk(b, hi);
    end
    #1;
    chk(intr, 1'b0);
    req = 8'h00;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    init(8'hbe, 8'h5a, 8'h00, 8'h00);
    svc(8'h08, 1'b0, 8'hac, 8'h5a);
    $display("test 1 done");
    init(8'hf8, 8'h12, 8'h00, 8'h00);
    svc(8'h20, 1'b0, 8'he8, 8'h12);
    $display("test 2 done");
    init(8'h1b, 8'ha8, 8'h00, 8'h01);
    cpu.wr(1'b1, 8'h10);
    svc(8'h50, 1'b1, 8'hae, 8'h00);
    $display("test 3 done");
    init(8'h12, 8'h33, 8'h00, 8'h00);
    svc(8'h50, 1'b0, 8'h20, 8'h33);
    $display("test 4 done");
    // Edge request for input 6 still latched, input 4 in service
    cpu.wr(1'b0, 8'h0b);
    cpu.wr(1'b1, 8'h81);
    cpu.rd(1'b0, b);
    chk(b, 8'h10);
    cpu.rd(1'b1, b);
    chk(b, 8'h81);
    init(8'h12, 8'h33, 8'h00, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(intr, 1'b0);
    cpu.rd(1'b0, b);
    chk(b, 8'h00);
    cpu.rd(1'b1, b);
    chk(b, 8'h00);
    $display("test 5 done");
    end_of_test();
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
